// *** channel_status_fault_srq_tb.sv ***
`timescale 1ns/1ps
// ****************************************
// Bench for the status and request core.
// ****************************************
module channel_status_fault_srq_tb;
	import csfs_pkg::*;
	logic            clk;
	logic            rst_n;
	logic            cmdBusy;
	logic            errorDetect;
	logic            lineDropout;
	logic            ponSrqEnable;
	logic [3:0][6:0] liveCond;
	logic [3:0]      rangeAutoSwitch;
	logic [3:0]      rangeKept;
	csfs_cmd_t       cmd;
	csfs_rsp_t       rsp;
	logic [7:0]      serialPollSummary;
	logic [7:0]      q;
	logic            srqOut;
	logic            srqIndicator;
	logic            errIndicator;
	int              mismatches;
	int              checks_done;
	// Three-channel build so that the top summary bit must stay low.
	csfs_status_core #(.NUM_CHANNELS(3)) u_dut (.clk(clk), .rst_n(rst_n), .clkEn(1'b1),
		.liveCond(liveCond), .rangeAutoSwitch(rangeAutoSwitch), .rangeKept(rangeKept),
		.cmd(cmd), .cmdBusy(cmdBusy), .errorDetect(errorDetect), .lineDropout(lineDropout),
		.ponSrqEnable(ponSrqEnable), .rsp(rsp), .serialPollSummary(serialPollSummary),
		.srqOut(srqOut), .srqIndicator(srqIndicator), .errIndicator(errIndicator));
	csfs_host_model u_host (.clk(clk), .cmd(cmd), .rsp(rsp));
	// Compares one byte and counts it.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		u_host.release_cmd();
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic send(input csfs_op_t o, input logic [1:0] ch, input logic [7:0] d);
		u_host.xfer(o, ch, d, q);
	endtask : send
	// Waits a bounded time for the bus request; a hang ends the run.
	task automatic wait_srq;
		int i;
		for (i = 0; i < 8 && srqOut !== 1'b1; i++) tick(1);
		if (srqOut !== 1'b1) begin
			mismatches++;
			print_verdict();
		end
		chk({7'h0, srqIndicator}, 8'h01);
	endtask : wait_srq
	task automatic s_reset;
		chk(serialPollSummary, 8'h90);
		cmdBusy = 1'b1;
		#1;
		chk(serialPollSummary, 8'h80);
		cmdBusy = 1'b0;
		send(CSFS_OP_MASK_Q, 2'd0, 8'h00);
		chk(q, 8'h00);
		chk({7'h0, srqOut}, 8'h00);
	endtask : s_reset
	task automatic s_fault;
		send(CSFS_OP_MASK_W, 2'd0, 8'h08);
		send(CSFS_OP_MASK_W, 2'd3, 8'h08);
		tick(2);
		liveCond[0][3] = 1'b1;
		liveCond[3][3] = 1'b1;
		tick(3);
		liveCond[0][3] = 1'b0;
		tick(2);
		chk({4'h0, serialPollSummary[3:0]}, 8'h01);
		send(CSFS_OP_SPOLL, 2'd0, 8'h00);
		chk(q, 8'h91);
		send(CSFS_OP_FAULT_Q, 2'd0, 8'h00);
		chk(q, 8'h08);
		send(CSFS_OP_FAULT_Q, 2'd0, 8'h00);
		chk(q, 8'h00);
		send(CSFS_OP_MASK_Q, 2'd0, 8'h00);
		chk(q, 8'h08);
		send(CSFS_OP_FAULT_Q, 2'd3, 8'h00);
		liveCond[3][3] = 1'b0;
	endtask : s_fault
	task automatic s_mask_rise;
		liveCond[1][0] = 1'b1;
		tick(2);
		send(CSFS_OP_MASK_W, 2'd1, 8'hFF);
		tick(4);
		send(CSFS_OP_FAULT_Q, 2'd1, 8'h00);
		chk(q, 8'h01);
		send(CSFS_OP_MASK_Q, 2'd1, 8'h00);
		chk(q, 8'hFF);
		send(CSFS_OP_FAULT_Q, 2'd1, 8'h00);
		chk(q, 8'h00);
		send(CSFS_OP_REPROG, 2'd1, 8'h00);
		tick(2);
		send(CSFS_OP_FAULT_Q, 2'd1, 8'h00);
		chk(q, 8'h01);
		liveCond[1][0] = 1'b0;
	endtask : s_mask_rise
	task automatic s_acc_range;
		liveCond[2][4] = 1'b1;
		tick(2);
		liveCond[2] = 7'h01;
		tick(2);
		send(CSFS_OP_ACC_Q, 2'd2, 8'h00);
		chk(q, 8'h11);
		send(CSFS_OP_ACC_Q, 2'd2, 8'h00);
		chk(q, 8'h01);
		rangeAutoSwitch[2] = 1'b1;
		tick(1);
		rangeAutoSwitch[2] = 1'b0;
		tick(1);
		send(CSFS_OP_LIVE_Q, 2'd2, 8'h00);
		chk(q, 8'h81);
		rangeKept[2] = 1'b1;
		tick(1);
		rangeKept[2] = 1'b0;
		tick(1);
		send(CSFS_OP_LIVE_Q, 2'd2, 8'h00);
		chk(q, 8'h01);
		liveCond[2] = 7'h00;
	endtask : s_acc_range
	task automatic s_srq;
		errorDetect = 1'b1;
		tick(1);
		errorDetect = 1'b0;
		tick(3);
		chk({7'h0, srqOut}, 8'h00);
		chk({7'h0, errIndicator}, 8'h01);
		send(CSFS_OP_SRQ_W, 2'd0, 8'h02);
		wait_srq();
		send(CSFS_OP_SPOLL, 2'd0, 8'h00);
		chk(q, 8'hF0);
		tick(1);
		chk(serialPollSummary, 8'hB0);
		send(CSFS_OP_ERR_Q, 2'd0, 8'h00);
		chk(q, 8'h01);
		tick(1);
		chk(serialPollSummary, 8'h90);
		send(CSFS_OP_SRQ_W, 2'd0, 8'h01);
		send(CSFS_OP_MASK_W, 2'd0, 8'h02);
		tick(2);
		liveCond[0][1] = 1'b1;
		wait_srq();
		send(CSFS_OP_FAULT_Q, 2'd0, 8'h00);
		chk(q, 8'h02);
		send(CSFS_OP_SPOLL, 2'd0, 8'h00);
		chk(q, 8'hD0);
		liveCond[0][1] = 1'b0;
		send(CSFS_OP_SRQ_W, 2'd0, 8'h03);
		send(CSFS_OP_SRQ_Q, 2'd0, 8'h00);
		chk(q, 8'h03);
	endtask : s_srq
	task automatic s_pon;
		send(CSFS_OP_CLEAR, 2'd0, 8'h00);
		tick(1);
		chk(serialPollSummary, 8'h10);
		ponSrqEnable = 1'b1;
		lineDropout = 1'b1;
		tick(1);
		lineDropout = 1'b0;
		wait_srq();
		chk(serialPollSummary, 8'hD0);
	endtask : s_pon
	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict;
		$display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict
	// Free-running 200 MHz clock.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Main sequence: reset for two cycles, then each scenario in turn.
	initial begin
		rst_n = 1'b0;
		cmdBusy = 1'b0;
		errorDetect = 1'b0;
		lineDropout = 1'b0;
		ponSrqEnable = 1'b0;
		liveCond = '0;
		rangeAutoSwitch = '0;
		rangeKept = '0;
		mismatches = 0;
		checks_done = 0;
		tick(2);
		rst_n = 1'b1;
		tick(1);
		s_reset();
		s_fault();
		s_mask_rise();
		s_acc_range();
		s_srq();
		s_pon();
		print_verdict();
	end
endmodule : channel_status_fault_srq_tb

// *** csfs_cfg.svh ***
`ifndef CSFS_CFG_SVH
`define CSFS_CFG_SVH
// Number of output channels in the largest build.
`define CSFS_MAX_CH       4
// Status bit positions, shared by live, accumulated, mask and fault.
`define CSFS_BIT_CV       0
`define CSFS_BIT_POSCC    1
`define CSFS_BIT_NEGCC    2
`define CSFS_BIT_OV       3
`define CSFS_BIT_OT       4
`define CSFS_BIT_UNR      5
`define CSFS_BIT_OC       6
`define CSFS_BIT_CP       7
// Fault bits that a reprogramming command re-arms (CV, +CC, -CC, UNREGULATED_FLAG).
`define CSFS_REPROG_BITS  8'h0_027
// Serial poll summary bit positions.
`define CSFS_SP_FAU_LO    0
`define CSFS_SP_IDLE      4
`define CSFS_SP_ERR       5
`define CSFS_SP_RQS       6
`define CSFS_SP_PON       7
// Reset values.
`define CSFS_RST_BYTE     8'h0_000
`define CSFS_RST_SRQ_MODE 2'h0
// Request-enable setting bits: bit 0 faults, bit 1 errors.
`define CSFS_SRQ_FAULT    0
`define CSFS_SRQ_ERROR    1
`endif

// *** csfs_host_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Remote bus controller issuing commands.
// ****************************************
module csfs_host_model (
	input  wire logic                clk,
	output csfs_pkg::csfs_cmd_t      cmd,
	input  wire csfs_pkg::csfs_rsp_t rsp
);
	import csfs_pkg::*;
	// The command strobe is idle until the first request.
	initial begin
		cmd = '0;
	end
	// Drops the strobe and scrambles the channel and data fields between commands; the operation is kept.
	task automatic release_cmd;
		if (cmd.valid) begin
			cmd = '{valid: 1'b0, op: cmd.op, chan: ~cmd.chan, data: ~cmd.data};
		end
	endtask : release_cmd
	// Holds one command across its taking edge; the strobe stays up until released.
	task automatic xfer(input csfs_op_t o, input logic [1:0] ch, input logic [7:0] d,
		output logic [7:0] q);
		cmd = '{valid: 1'b1, op: o, chan: ch, data: d};
		@(posedge clk);
		#1;
		q = rsp.valid ? rsp.data : 8'hxx; // A missing answer never matches.
	endtask : xfer
endmodule : csfs_host_model

// *** csfs_pkg.sv ***
package csfs_pkg;
	// Host operations carried by a command strobe.
	typedef enum logic [3:0] {
		CSFS_OP_LIVE_Q   = 4'h0,
		CSFS_OP_ACC_Q    = 4'h1,
		CSFS_OP_MASK_Q   = 4'h2,
		CSFS_OP_MASK_W   = 4'h3,
		CSFS_OP_FAULT_Q  = 4'h4,
		CSFS_OP_REPROG   = 4'h5,
		CSFS_OP_SRQ_W    = 4'h6,
		CSFS_OP_SRQ_Q    = 4'h7,
		CSFS_OP_ERR_Q    = 4'h8,
		CSFS_OP_CLEAR    = 4'h9,
		CSFS_OP_SPOLL    = 4'hA
	} csfs_op_t;

	// One host command: strobe, operation, channel (0 = first) and data.
	typedef struct packed {
		logic       valid;
		csfs_op_t   op;
		logic [1:0] chan;
		logic [7:0] data;
	} csfs_cmd_t;

	// Answer to a query.
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} csfs_rsp_t;
endpackage : csfs_pkg

// *** csfs_status_core.sv ***
`timescale 1ns/1ps
`include "csfs_cfg.svh"
// Operation
// - Eight-bit channel status with fixed bit layout.
// - Range coupling set on auto switch, cleared on range kept.
// - Status from inputs only; mask from host only.
// - Accumulated status ORs; read reloads live status.
// - Mask and fault eight bits, status layout.
// - Fault set on unmasked status rising edge.
// - Fault set when mask rises over set status.
// - Fault read clears; steady bits stay clear.
// - Reprogramming commands re-arm CV, CC, UNREGULATED_FLAG faults.
// - Fault bits stay latched until read or clear command.
// - Channel fault summary is OR of fault.
// - Serial poll byte layout fixed.
// - Absent channel summary bits read zero.
// - Idle bit high when command processing done.
// - Error bit set on error, cleared by query.
// - Request bit set on request, cleared by poll.
// - Power-on bit cleared only by clear command.
// - Request raises bit, indicator and bus line.
// - Faults request service at setting 1 or 3.
// - Errors request service at setting 2 or 3.
// - Power-on and dropout set bit; optional request.
// - Request-enable setting takes values 0 to 3.
// - Serial poll never clears fault registers.
module csfs_status_core #(
	parameter int NUM_CHANNELS = `CSFS_MAX_CH
) (
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	input  wire logic                           clkEn,
	input  wire logic [`CSFS_MAX_CH-1:0][6:0]   liveCond,
	input  wire logic [`CSFS_MAX_CH-1:0]        rangeAutoSwitch,
	input  wire logic [`CSFS_MAX_CH-1:0]        rangeKept,
	input  wire csfs_pkg::csfs_cmd_t            cmd,
	input  wire logic                           cmdBusy,
	input  wire logic                           errorDetect,
	input  wire logic                           lineDropout,
	input  wire logic                           ponSrqEnable,
	output csfs_pkg::csfs_rsp_t                 rsp,
	output logic [7:0]                          serialPollSummary,
	output logic                                srqOut,
	output logic                                srqIndicator,
	output logic                                errIndicator
);
	import csfs_pkg::*;

	// ************************************************************
	// Per-channel registers
	// ************************************************************

	logic [7:0] accStatus [`CSFS_MAX_CH];
	logic [7:0] faultMask [`CSFS_MAX_CH];
	logic [7:0] faultLatch [`CSFS_MAX_CH];
	logic [7:0] prevStatus [`CSFS_MAX_CH];
	logic [7:0] prevMask [`CSFS_MAX_CH];
	logic [`CSFS_MAX_CH-1:0] rangeCoupling;
	logic [7:0] liveStatus [`CSFS_MAX_CH];
	logic [7:0] next_acc [`CSFS_MAX_CH];
	logic [7:0] next_mask [`CSFS_MAX_CH];
	logic [7:0] next_fault [`CSFS_MAX_CH];
	logic [7:0] faultSet [`CSFS_MAX_CH];
	logic [`CSFS_MAX_CH-1:0] faultAny;
	logic [`CSFS_MAX_CH-1:0] chanPresent;

	// ************************************************************
	// Summary and request state
	// ************************************************************

	logic       powerup;
	logic       errFlag;
	logic       requestService;
	logic [1:0] srqMode;
	logic       srqCondPrev;
	logic       srqCond;
	logic [7:0] spByte;

	// Command decode.
	wire cmdGo      = cmd.valid;
	wire isAccQ     = cmdGo && (cmd.op == CSFS_OP_ACC_Q);
	wire isMaskW    = cmdGo && (cmd.op == CSFS_OP_MASK_W);
	wire isFaultQ   = cmdGo && (cmd.op == CSFS_OP_FAULT_Q);
	wire isReprog   = cmdGo && (cmd.op == CSFS_OP_REPROG);
	wire isSrqW     = cmdGo && (cmd.op == CSFS_OP_SRQ_W);
	wire isErrQ     = cmdGo && (cmd.op == CSFS_OP_ERR_Q);
	wire isClear    = cmdGo && (cmd.op == CSFS_OP_CLEAR);
	wire isSpoll    = cmdGo && (cmd.op == CSFS_OP_SPOLL);

	// Fault bits raised by a status edge, a mask edge or a reprogram.
	function automatic logic [7:0] calcFaultSet(
		input logic [7:0] status,
		input logic [7:0] oldStatus,
		input logic [7:0] mask,
		input logic [7:0] oldMask,
		input logic       reprog
	);
		logic [7:0] edgeBits;
		edgeBits = (status & ~oldStatus & mask)
			| (mask & ~oldMask & status);
		if (reprog) begin
			edgeBits = edgeBits | (status & mask & `CSFS_REPROG_BITS);
		end
		return edgeBits;
	endfunction : calcFaultSet

	// Next values for each channel's registers.
	genvar g;
	generate
		for (g = 0; g < `CSFS_MAX_CH; g++) begin : gChan
			wire sel = (cmd.chan == 2'(g));
			assign chanPresent[g] = (g < NUM_CHANNELS);
			// Live status is the condition inputs plus range coupling.
			assign liveStatus[g] = {rangeCoupling[g], liveCond[g]};
			assign faultSet[g] = calcFaultSet(liveStatus[g], prevStatus[g],
				faultMask[g], prevMask[g], isReprog && sel);
			assign next_acc[g] = (isAccQ && sel) ? liveStatus[g]
				: (accStatus[g] | liveStatus[g]);
			assign next_mask[g] = isClear ? `CSFS_RST_BYTE
				: ((isMaskW && sel) ? cmd.data : faultMask[g]);
			// A new fault in the read cycle survives the clear.
			assign next_fault[g] = (isClear ? `CSFS_RST_BYTE
				: ((isFaultQ && sel) ? `CSFS_RST_BYTE : faultLatch[g]))
				| faultSet[g];
			assign faultAny[g] = chanPresent[g] && (|faultLatch[g]);
		end
	endgenerate

	// Channel registers, frozen while the clock enable is low.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int c = 0; c < `CSFS_MAX_CH; c++) begin
				accStatus[c]  <= `CSFS_RST_BYTE;
				faultMask[c]  <= `CSFS_RST_BYTE;
				faultLatch[c] <= `CSFS_RST_BYTE;
				prevStatus[c] <= `CSFS_RST_BYTE;
				prevMask[c]   <= `CSFS_RST_BYTE;
			end
		end else if (clkEn) begin
			for (int c = 0; c < `CSFS_MAX_CH; c++) begin
				accStatus[c]  <= next_acc[c];
				faultMask[c]  <= next_mask[c];
				faultLatch[c] <= next_fault[c];
				prevStatus[c] <= liveStatus[c];
				prevMask[c]   <= faultMask[c];
			end
		end
	end

	// Range coupling flag: an automatic switch sets it and wins.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rangeCoupling <= '0;
		end else if (clkEn) begin
			rangeCoupling <= (rangeCoupling & ~rangeKept) | rangeAutoSwitch;
		end
	end

	// ************************************************************
	// Serial poll summary and service request
	// ************************************************************

	// Request condition from faults, errors and power-on.
	assign srqCond = ((|faultAny) && srqMode[`CSFS_SRQ_FAULT])
		| (errFlag && srqMode[`CSFS_SRQ_ERROR])
		| (powerup && ponSrqEnable);

	// Summary byte assembly.
	assign spByte = {powerup, requestService, errFlag, !cmdBusy,
		faultAny};

	// Power-on, error, request and mode state.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			powerup        <= 1'b1;
			errFlag        <= 1'b0;
			requestService <= 1'b0;
			srqMode        <= `CSFS_RST_SRQ_MODE;
			srqCondPrev    <= 1'b0;
		end else if (clkEn) begin
			powerup        <= (powerup && !isClear) || lineDropout;
			errFlag        <= (errFlag && !isErrQ) || errorDetect;
			requestService <= (requestService && !isSpoll)
				|| (srqCond && !srqCondPrev);
			srqCondPrev    <= srqCond;
			if (isClear) begin
				srqMode <= `CSFS_RST_SRQ_MODE;
			end else if (isSrqW) begin
				srqMode <= cmd.data[1:0];
			end
		end
	end

	// Query answers, one cycle after the command.
	logic [7:0] rspSel;
	always_comb begin
		rspSel = `CSFS_RST_BYTE;
		case (cmd.op)
			CSFS_OP_LIVE_Q:  rspSel = liveStatus[cmd.chan];
			CSFS_OP_ACC_Q:   rspSel = accStatus[cmd.chan] | liveStatus[cmd.chan];
			CSFS_OP_MASK_Q:  rspSel = faultMask[cmd.chan];
			CSFS_OP_FAULT_Q: rspSel = faultLatch[cmd.chan];
			CSFS_OP_SRQ_Q:   rspSel = {6'h0_0, srqMode};
			CSFS_OP_ERR_Q:   rspSel = {7'h0_0, errFlag};
			CSFS_OP_SPOLL:   rspSel = spByte;
			default:         rspSel = `CSFS_RST_BYTE;
		endcase
	end

	wire isQuery = cmdGo && !isMaskW && !isReprog && !isSrqW && !isClear;

	// Answer register.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rsp <= '0;
		end else if (clkEn) begin
			rsp.valid <= isQuery;
			rsp.data  <= isQuery ? rspSel : rsp.data;
		end
	end

	// Outputs to the bus and front panel.
	assign serialPollSummary = spByte;
	assign srqOut            = requestService;
	assign srqIndicator      = requestService;
	assign errIndicator      = errFlag;

	// ************************************************************
	// Checks
	// ************************************************************

	chk_fault_rise_set: assert property (@(posedge clk) disable iff (!rst_n)
		clkEn && !isClear && (|(liveStatus[0] & ~prevStatus[0] & faultMask[0]))
		|=> ((faultLatch[0] & $past(liveStatus[0] & ~prevStatus[0] & faultMask[0]))
			== $past(liveStatus[0] & ~prevStatus[0] & faultMask[0])))
		else $error("Unmasked status rise did not latch a fault.");

	chk_fault_read_clr: assert property (@(posedge clk) disable iff (!rst_n)
		clkEn && isFaultQ && cmd.chan == 2'h0 && faultSet[0] == 8'h0_0
		|=> faultLatch[0] == 8'h0_0)
		else $error("Fault read did not clear the fault register.");

	chk_fault_holds: assert property (@(posedge clk) disable iff (!rst_n)
		clkEn && !isClear && !(isFaultQ && cmd.chan == 2'h0)
		|=> (faultLatch[0] & $past(faultLatch[0])) == $past(faultLatch[0]))
		else $error("Fault bit dropped without a read.");

	chk_spoll_keeps: assert property (@(posedge clk) disable iff (!rst_n)
		clkEn && isSpoll |=> faultLatch[1] == ($past(faultLatch[1]) | $past(faultSet[1])))
		else $error("Serial poll altered a fault register.");

	chk_fau_summary: assert property (@(posedge clk) disable iff (!rst_n)
		spByte[0] == (|faultLatch[0]))
		else $error("Channel summary bit disagrees with fault register.");

	chk_absent_zero: assert property (@(posedge clk) disable iff (!rst_n)
		NUM_CHANNELS < 4 |-> spByte[3] == 1'b0)
		else $error("Absent channel summary bit is set.");

	chk_err_clear: assert property (@(posedge clk) disable iff (!rst_n)
		clkEn && isErrQ && !errorDetect |=> !errFlag)
		else $error("Error query did not clear the error bit.");

	chk_rqs_raise: assert property (@(posedge clk) disable iff (!rst_n)
		clkEn && srqCond && !srqCondPrev |=> srqOut && srqIndicator)
		else $error("Service request not raised on a new condition.");

	chk_rqs_poll: assert property (@(posedge clk) disable iff (!rst_n)
		clkEn && isSpoll && !(srqCond && !srqCondPrev) |=> !requestService)
		else $error("Serial poll did not clear the request bit.");

	chk_pon_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		powerup && !(clkEn && isClear) |=> powerup)
		else $error("Power-on bit cleared without a clear command.");

	chk_acc_reload: assert property (@(posedge clk) disable iff (!rst_n)
		clkEn && isAccQ && cmd.chan == 2'h0
		|=> accStatus[0] == $past(liveStatus[0]))
		else $error("Accumulated status did not reload.");

	chk_cp_set: assert property (@(posedge clk) disable iff (!rst_n)
		clkEn && rangeAutoSwitch[0] |=> rangeCoupling[0])
		else $error("Range coupling flag not set on automatic switch.");

	chk_fault_srq: assert property (@(posedge clk) disable iff (!rst_n)
		(|faultAny) && srqMode == 2'h0 && !errFlag && !powerup |-> !srqCond)
		else $error("Fault requested service with faults disabled.");

endmodule : csfs_status_core
